// ===== rtl/rrx_exec.sv
// Execute stage for register, RAM pointer and RAM transfer instructions
//
// Behaviour
// RL1: copy_acc_to_digit_ptr loads digit pointer from accumulator, one cycle, carry untouched.
// RL2: set_rom_upper_flag sets rom_upper_enable; nothing else here changes it.
// RL3: rom_lookup_read loads carry from word bit 8 only when rom_upper_enable set.
// RL4: clear_watchdog_flag clears watchdog_flag_one in one cycle, no carry change, no skip.
// RL5: load_acc_from_ram copies addressed RAM nibble into accumulator, RAM kept.
// RL6: The three swap instructions exchange accumulator and addressed RAM nibble in one cycle.
// RL7: After RAM access the four RAM transfers xor the file pointer with j.
// RL8: swap_and_dec and dec_digit_ptr decrement digit pointer; skip next when result is 15.
// RL9: swap_and_inc and inc_digit_ptr increment digit pointer; skip next when result is 0.
// RL10: load_pointer_pair loads both pointers; directly following pair loads are skipped.
// RL11: copy_upper_to_acc loads accumulator from B in one cycle, carry untouched.
// RL12: copy_acc_to_upper loads B from accumulator in one cycle, carry untouched.
// RL13: copy_ptr_to_acc loads accumulator from digit pointer in one cycle, carry untouched.
// RL14: pack_into_wide writes B to E high nibble and accumulator to E low.
// RL15: unpack_wide loads B from E high nibble and accumulator from E low.
// RL16: load_page_ptr loads D from the three low accumulator bits.
// RL17: A skipped instruction is fetched and all its effects but the pair-load mark for RL10 are suppressed, one cycle.
// RL18: ram_pointer is file pointer concatenated with digit pointer, addressing 64 nibbles.
`timescale 1ns/1ns
`include "rrx_cfg.svh"
module rrx_exec
  import rrx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       instr_valid,
  input  wire logic [8:0] instr,
  input  wire logic [3:0] ram_rdata,
  output logic      [5:0] ram_addr,
  output logic      [3:0] ram_wdata,
  output logic            ram_we,
  output logic            lookup_start,
  input  wire logic       lookup_done,
  input  wire logic [8:0] lookup_word,
  input  wire logic       watchdog_set,
  output logic            skip_next,
  output logic      [3:0] acc_r,
  output logic      [3:0] upper_r,
  output logic      [1:0] file_ptr,
  output logic      [3:0] digit_ptr,
  output logic      [2:0] page_r,
  output logic      [7:0] wide_r,
  output logic            carry_flag_r,
  output logic            rom_upper_enable_r,
  output logic            watchdog_flag_one_r
);

  // ============================================================
  // Decode
  rrx_ctl_if ctl ();

  rrx_decode u_decode (
    .instr (instr),
    .ctl   (ctl.dec)
  );

  logic       skip_pend_r;
  logic       prev_pair_r;
  logic       exec_en;
  logic       ptr_skip;
  logic [3:0] acc_nxt;
  logic [3:0] upper_nxt;

  // A pending skip, or a pair load right after another, turns the word into a no-op
  wire logic is_pair  = ctl.op == RRX_OP_PTR_PAIR;
  wire logic suppress = skip_pend_r || (is_pair && prev_pair_r); // RL10 RL17
  assign exec_en = instr_valid && !suppress; // RL17

  // ============================================================
  // Pointer unit
  rrx_ptr u_ptr (
    .clk         (clk),
    .rst         (rst),
    .exec_en     (exec_en),
    .acc         (acc_r),
    .ctl         (ctl.use_side),
    .file_ptr_r  (file_ptr),
    .digit_ptr_r (digit_ptr),
    .skip_hit    (ptr_skip)
  );

  // ============================================================
  // RAM port: address from the pointers before they update
  wire logic ram_load = ctl.op == RRX_OP_LOAD_RAM;
  wire logic ram_swap = ctl.op inside {RRX_OP_SWAP_RAM, RRX_OP_SWAP_DEC, RRX_OP_SWAP_INC};
  assign ram_addr  = {file_ptr, digit_ptr}; // RL18
  assign ram_wdata = acc_r;                 // RL6
  assign ram_we    = exec_en && ram_swap;   // RL6
  assign skip_next = ptr_skip;

  // Lookup is fetched by the core; only its returned word lands here
  assign lookup_start = exec_en && ctl.op == RRX_OP_ROM_LOOKUP;

  // ============================================================
  // Accumulator and B next values
  always_comb begin
    acc_nxt   = acc_r;
    upper_nxt = upper_r;
    if (exec_en) begin
      unique case (ctl.op)
        RRX_OP_UPPER_TO_ACC: acc_nxt = upper_r;   // RL11
        RRX_OP_ACC_TO_UPPER: upper_nxt = acc_r;   // RL12
        RRX_OP_PTR_TO_ACC:   acc_nxt = digit_ptr; // RL13
        RRX_OP_UNPACK: begin
          upper_nxt = wide_r[`RRX_HI_NIB_H:`RRX_HI_NIB_L]; // RL15
          acc_nxt   = wide_r[`RRX_LO_NIB_H:`RRX_LO_NIB_L]; // RL15
        end
        RRX_OP_LOAD_RAM, RRX_OP_SWAP_RAM,
        RRX_OP_SWAP_DEC, RRX_OP_SWAP_INC: acc_nxt = ram_rdata; // RL5 RL6
        default: ;
      endcase
    end
    // Lookup data returns some cycles after issue, on its own strobe
    if (lookup_done) begin
      upper_nxt = lookup_word[`RRX_HI_NIB_H:`RRX_HI_NIB_L];
      acc_nxt   = lookup_word[`RRX_LO_NIB_H:`RRX_LO_NIB_L];
    end
  end

  // ============================================================
  // Data registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r   <= `RRX_RST_NIB;
      upper_r <= `RRX_RST_NIB;
    end else begin
      acc_r   <= acc_nxt;
      upper_r <= upper_nxt;
    end
  end

  // E and D registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_r <= `RRX_RST_E;
      page_r <= `RRX_RST_D;
    end else if (exec_en && ctl.op == RRX_OP_PACK) begin
      wide_r <= {upper_r, acc_r}; // RL14
    end else if (exec_en && ctl.op == RRX_OP_PAGE_PTR) begin
      page_r <= acc_r[`RRX_PAGE_H:`RRX_PAGE_L]; // RL16
    end
  end

  // ============================================================
  // Flags; carry moves only on a lookup return with the upper flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_flag_r       <= 1'h0;
      rom_upper_enable_r <= 1'h0;
    end else begin
      if (lookup_done && rom_upper_enable_r) begin
        carry_flag_r <= lookup_word[`RRX_ROM_TOP]; // RL3
      end
      if (exec_en && ctl.op == RRX_OP_SET_ROM_UPPER) begin
        rom_upper_enable_r <= 1'h1; // RL2
      end
    end
  end

  // Watchdog flag: the timer's set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_flag_one_r <= 1'h0;
    end else if (watchdog_set) begin
      watchdog_flag_one_r <= 1'h1;
    end else if (exec_en && ctl.op == RRX_OP_CLR_WATCHDOG) begin
      watchdog_flag_one_r <= 1'h0; // RL4
    end
  end

  // ============================================================
  // Skip state: one pending skip consumes the next fetched word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_pend_r <= 1'h0;
      prev_pair_r <= 1'h0;
    end else if (instr_valid) begin
      skip_pend_r <= ptr_skip; // RL8 RL9 RL17
      prev_pair_r <= is_pair;  // RL10
    end
  end

endmodule

// ===== rtl/rrx_cfg.svh
// Opcode, mask and reset-value constants for the transfer execute stage
`ifndef RRX_CFG_SVH
`define RRX_CFG_SVH

// ============================================================
// Instruction codes (9-bit words)
`define RRX_OPC_COPY_UPPER_TO_ACC 9'h01E
`define RRX_OPC_COPY_ACC_TO_UPPER 9'h00E
`define RRX_OPC_COPY_PTR_TO_ACC   9'h01F
`define RRX_OPC_COPY_ACC_TO_DPTR  9'h00C
`define RRX_OPC_PACK_INTO_WIDE    9'h01A
`define RRX_OPC_UNPACK_WIDE       9'h02A
`define RRX_OPC_LOAD_PAGE_PTR     9'h029
`define RRX_OPC_INC_DIGIT_PTR     9'h013
`define RRX_OPC_DEC_DIGIT_PTR     9'h017
`define RRX_OPC_SET_ROM_UPPER     9'h082
`define RRX_OPC_CLEAR_WATCHDOG    9'h00F
`define RRX_OPC_LOAD_ACC_FROM_RAM 9'h064
`define RRX_OPC_SWAP_ACC_RAM      9'h060
`define RRX_OPC_SWAP_AND_DEC      9'h06C
`define RRX_OPC_SWAP_AND_INC      9'h068
`define RRX_OPC_LOAD_PTR_PAIR     9'h0C0
`define RRX_OPC_ROM_LOOKUP        9'h090

// ============================================================
// Masks for opcodes carrying immediates
`define RRX_MASK_J      9'h1FC
`define RRX_MASK_PAIR   9'h1C0
`define RRX_MASK_LOOKUP 9'h1F0

// ============================================================
// Field positions
`define RRX_J_HI     1
`define RRX_J_LO     0
`define RRX_X_HI     5
`define RRX_X_LO     4
`define RRX_Y_HI     3
`define RRX_Y_LO     0
`define RRX_ROM_TOP  8
`define RRX_HI_NIB_H 7
`define RRX_HI_NIB_L 4
`define RRX_LO_NIB_H 3
`define RRX_LO_NIB_L 0
`define RRX_PAGE_H   2
`define RRX_PAGE_L   0

// ============================================================
// Reset values and pointer limits
`define RRX_RST_NIB  4'h0
`define RRX_RST_FP   2'h0
`define RRX_RST_D    3'h0
`define RRX_RST_E    8'h00
`define RRX_DPTR_MAX 4'hF
`define RRX_DPTR_MIN 4'h0
`define RRX_DPTR_ONE 4'h1

`endif

// ===== rtl/rrx_pkg.sv
// Types shared by the transfer execute stage modules
package rrx_pkg;

  // ============================================================
  // Decoded operation
  typedef enum logic [4:0] {
    RRX_OP_NONE,
    RRX_OP_UPPER_TO_ACC,
    RRX_OP_ACC_TO_UPPER,
    RRX_OP_PTR_TO_ACC,
    RRX_OP_ACC_TO_DPTR,
    RRX_OP_PACK,
    RRX_OP_UNPACK,
    RRX_OP_PAGE_PTR,
    RRX_OP_INC_DPTR,
    RRX_OP_DEC_DPTR,
    RRX_OP_SET_ROM_UPPER,
    RRX_OP_CLR_WATCHDOG,
    RRX_OP_LOAD_RAM,
    RRX_OP_SWAP_RAM,
    RRX_OP_SWAP_DEC,
    RRX_OP_SWAP_INC,
    RRX_OP_PTR_PAIR,
    RRX_OP_ROM_LOOKUP
  } rrx_op_t;

endpackage

// ===== rtl/rrx_ctl_if.sv
// Decoded-instruction carrier between decoder and its users
`timescale 1ns/1ns
interface rrx_ctl_if;
  import rrx_pkg::*;
  rrx_op_t    op;
  logic [1:0] imm_j;
  logic [1:0] imm_x;
  logic [3:0] imm_y;
  modport dec (output op, output imm_j, output imm_x, output imm_y);
  modport use_side (input op, input imm_j, input imm_x, input imm_y);
endinterface

// ===== rtl/rrx_decode.sv
// Instruction decoder for the transfer group
`timescale 1ns/1ns
`include "rrx_cfg.svh"
module rrx_decode
  import rrx_pkg::*;
(
  input  wire logic [8:0] instr,
  rrx_ctl_if.dec          ctl
);

  // ============================================================
  // Opcode matches; immediates are masked off before comparing
  wire logic [8:0] op_j      = instr & `RRX_MASK_J;
  wire logic       hit_pair  = (instr & `RRX_MASK_PAIR) == `RRX_OPC_LOAD_PTR_PAIR;
  wire logic       hit_look  = (instr & `RRX_MASK_LOOKUP) == `RRX_OPC_ROM_LOOKUP;
  wire logic       hit_lram  = op_j == `RRX_OPC_LOAD_ACC_FROM_RAM;
  wire logic       hit_swap  = op_j == `RRX_OPC_SWAP_ACC_RAM;
  wire logic       hit_sdec  = op_j == `RRX_OPC_SWAP_AND_DEC;
  wire logic       hit_sinc  = op_j == `RRX_OPC_SWAP_AND_INC;

  // Priority chain; codes are disjoint so order only matters for readability
  assign ctl.op =
    hit_pair                            ? RRX_OP_PTR_PAIR :
    hit_look                            ? RRX_OP_ROM_LOOKUP :
    hit_lram                            ? RRX_OP_LOAD_RAM :
    hit_swap                            ? RRX_OP_SWAP_RAM :
    hit_sdec                            ? RRX_OP_SWAP_DEC :
    hit_sinc                            ? RRX_OP_SWAP_INC :
    instr == `RRX_OPC_COPY_UPPER_TO_ACC ? RRX_OP_UPPER_TO_ACC :
    instr == `RRX_OPC_COPY_ACC_TO_UPPER ? RRX_OP_ACC_TO_UPPER :
    instr == `RRX_OPC_COPY_PTR_TO_ACC   ? RRX_OP_PTR_TO_ACC :
    instr == `RRX_OPC_COPY_ACC_TO_DPTR  ? RRX_OP_ACC_TO_DPTR :
    instr == `RRX_OPC_PACK_INTO_WIDE    ? RRX_OP_PACK :
    instr == `RRX_OPC_UNPACK_WIDE       ? RRX_OP_UNPACK :
    instr == `RRX_OPC_LOAD_PAGE_PTR     ? RRX_OP_PAGE_PTR :
    instr == `RRX_OPC_INC_DIGIT_PTR     ? RRX_OP_INC_DPTR :
    instr == `RRX_OPC_DEC_DIGIT_PTR     ? RRX_OP_DEC_DPTR :
    instr == `RRX_OPC_SET_ROM_UPPER     ? RRX_OP_SET_ROM_UPPER :
    instr == `RRX_OPC_CLEAR_WATCHDOG    ? RRX_OP_CLR_WATCHDOG :
                                          RRX_OP_NONE;

  // Immediate fields
  assign ctl.imm_j = instr[`RRX_J_HI:`RRX_J_LO];
  assign ctl.imm_x = instr[`RRX_X_HI:`RRX_X_LO];
  assign ctl.imm_y = instr[`RRX_Y_HI:`RRX_Y_LO];

endmodule

// ===== rtl/rrx_ptr.sv
// RAM file and digit pointer unit with pointer skip detection
`timescale 1ns/1ns
`include "rrx_cfg.svh"
module rrx_ptr
  import rrx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       exec_en,
  input  wire logic [3:0] acc,
  rrx_ctl_if.use_side     ctl,
  output logic      [1:0] file_ptr_r,
  output logic      [3:0] digit_ptr_r,
  output logic            skip_hit
);

  logic [1:0] file_ptr_nxt;
  logic [3:0] digit_ptr_nxt;

  // ============================================================
  // Operation classes
  wire logic is_ram  = ctl.op inside {RRX_OP_LOAD_RAM, RRX_OP_SWAP_RAM,
                                      RRX_OP_SWAP_DEC, RRX_OP_SWAP_INC};
  wire logic is_dec  = ctl.op inside {RRX_OP_SWAP_DEC, RRX_OP_DEC_DPTR};
  wire logic is_inc  = ctl.op inside {RRX_OP_SWAP_INC, RRX_OP_INC_DPTR};
  wire logic is_pair = ctl.op == RRX_OP_PTR_PAIR;
  wire logic is_tya  = ctl.op == RRX_OP_ACC_TO_DPTR;

  // Four-bit arithmetic wraps modulo 16 by width alone
  wire logic [3:0] dptr_dec = digit_ptr_r - `RRX_DPTR_ONE; // RL8
  wire logic [3:0] dptr_inc = digit_ptr_r + `RRX_DPTR_ONE; // RL9

  // Next pointer values; xor is applied after the RAM access uses the old pointer
  assign file_ptr_nxt  = is_pair ? ctl.imm_x :              // RL10
                         is_ram  ? file_ptr_r ^ ctl.imm_j : // RL7
                                   file_ptr_r;
  assign digit_ptr_nxt = is_pair ? ctl.imm_y : // RL10
                         is_tya  ? acc :       // RL1
                         is_dec  ? dptr_dec :
                         is_inc  ? dptr_inc :
                                   digit_ptr_r;

  // Skip request on wrap of the digit pointer
  assign skip_hit = exec_en && ((is_dec && dptr_dec == `RRX_DPTR_MAX) || // RL8
                                (is_inc && dptr_inc == `RRX_DPTR_MIN));  // RL9

  // Pointer registers update only on executed instructions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_ptr_r  <= `RRX_RST_FP;
      digit_ptr_r <= `RRX_RST_NIB;
    end else if (exec_en) begin
      file_ptr_r  <= file_ptr_nxt;
      digit_ptr_r <= digit_ptr_nxt;
    end
  end

endmodule

// ===== test/rrx_exec_chk.sv
// Port-level assertion checker for the transfer execute stage
`timescale 1ns/1ns
`include "rrx_cfg.svh"
module rrx_exec_chk
  import rrx_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       instr_valid,
  input wire logic [8:0] instr,
  input wire logic [3:0] ram_rdata,
  input wire logic [5:0] ram_addr,
  input wire logic       ram_we,
  input wire logic       lookup_done,
  input wire logic [8:0] lookup_word,
  input wire logic       watchdog_set,
  input wire logic       skip_next,
  input wire logic [3:0] acc_r,
  input wire logic [3:0] upper_r,
  input wire logic [1:0] file_ptr,
  input wire logic [3:0] digit_ptr,
  input wire logic [2:0] page_r,
  input wire logic [7:0] wide_r,
  input wire logic       carry_flag_r,
  input wire logic       rom_upper_enable_r,
  input wire logic       watchdog_flag_one_r
);
  // ============================================================
  // Shadow of the suppression state, so all checks but a_addr and a_look see only executed words
  logic pend_r;
  logic pair_r;
  wire logic [8:0] jop = instr & `RRX_MASK_J;
  wire logic is_pair = (instr & `RRX_MASK_PAIR) == `RRX_OPC_LOAD_PTR_PAIR;
  wire logic ex = instr_valid && !pend_r && !(is_pair && pair_r);
  wire logic is_swap = jop == `RRX_OPC_SWAP_ACC_RAM || jop == `RRX_OPC_SWAP_AND_DEC
                       || jop == `RRX_OPC_SWAP_AND_INC;
  wire logic is_ram = is_swap || jop == `RRX_OPC_LOAD_ACC_FROM_RAM;
  wire logic is_dec = ex && (instr == `RRX_OPC_DEC_DIGIT_PTR || jop == `RRX_OPC_SWAP_AND_DEC);
  wire logic is_inc = ex && (instr == `RRX_OPC_INC_DIGIT_PTR || jop == `RRX_OPC_SWAP_AND_INC);

  // Idle cycles keep a pending skip, so only valid words move this state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'h0;
      pair_r <= 1'h0;
    end else if (instr_valid) begin
      pend_r <= skip_next;
      pair_r <= is_pair;
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_addr; ram_addr == {file_ptr, digit_ptr}; endproperty
  a_addr: assert property (p_addr) else $error("ram address not pointer pair");
  property p_dptr; ex && instr == `RRX_OPC_COPY_ACC_TO_DPTR |=>
    digit_ptr == $past(acc_r) && $stable(carry_flag_r); endproperty
  a_dptr: assert property (p_dptr) else $error("digit pointer copy wrong");
  property p_urs; $rose(rom_upper_enable_r) |-> $past(ex && instr == `RRX_OPC_SET_ROM_UPPER);
  endproperty
  a_urs: assert property (p_urs) else $error("upper flag set without its op");
  property p_look; lookup_done |=> carry_flag_r ==
    ($past(rom_upper_enable_r) ? $past(lookup_word[8]) : $past(carry_flag_r)); endproperty
  a_look: assert property (p_look) else $error("lookup carry wrong");
  property p_wdt; ex && instr == `RRX_OPC_CLEAR_WATCHDOG && !watchdog_set |->
    !skip_next ##1 !watchdog_flag_one_r && $stable(carry_flag_r); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag clear wrong");
  property p_load; ex && jop == `RRX_OPC_LOAD_ACC_FROM_RAM |->
    !ram_we ##1 acc_r == $past(ram_rdata); endproperty
  a_load: assert property (p_load) else $error("ram load wrong");
  property p_we; ram_we == (ex && is_swap); endproperty
  a_we: assert property (p_we) else $error("ram write strobe wrong");
  property p_xor; ex && is_ram |=> file_ptr == ($past(file_ptr) ^ $past(instr[1:0])); endproperty
  a_xor: assert property (p_xor) else $error("file pointer xor wrong");
  property p_dec; is_dec |-> skip_next == (digit_ptr == `RRX_DPTR_MIN)
    ##1 digit_ptr == $past(digit_ptr) - 4'h1; endproperty
  a_dec: assert property (p_dec) else $error("decrement or its skip wrong");
  property p_inc; is_inc |-> skip_next == (digit_ptr == `RRX_DPTR_MAX)
    ##1 digit_ptr == $past(digit_ptr) + 4'h1; endproperty
  a_inc: assert property (p_inc) else $error("increment or its skip wrong");
  property p_pack; ex && instr == `RRX_OPC_PACK_INTO_WIDE |=>
    wide_r == {$past(upper_r), $past(acc_r)}; endproperty
  a_pack: assert property (p_pack) else $error("pack wrong");
  property p_page; ex && instr == `RRX_OPC_LOAD_PAGE_PTR |=> page_r == $past(acc_r[2:0]);
  endproperty
  a_page: assert property (p_page) else $error("page pointer wrong");
endmodule

bind rrx_exec rrx_exec_chk i_rrx_exec_chk (.clk, .rst, .instr_valid, .instr, .ram_rdata,
  .ram_addr, .ram_we, .lookup_done, .lookup_word, .watchdog_set, .skip_next, .acc_r,
  .upper_r, .file_ptr, .digit_ptr, .page_r, .wide_r, .carry_flag_r, .rom_upper_enable_r,
  .watchdog_flag_one_r);

// ===== test/rrx_exec_tb_top.sv
// Self-checking bench for the transfer execute stage
`timescale 1ns/1ns
`include "rrx_cfg.svh"
module rrx_exec_tb_top;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       instr_valid = 1'h0;
  logic [8:0] instr = 9'h000;
  logic       lookup_done = 1'h0;
  logic [8:0] lookup_word = 9'h000;
  logic       watchdog_set = 1'h0;
  logic [3:0] ram_rdata, ram_wdata, acc_r, upper_r, digit_ptr;
  logic [5:0] ram_addr;
  logic [1:0] file_ptr;
  logic [2:0] page_r;
  logic [7:0] wide_r;
  logic       ram_we, lookup_start, skip_next, carry_flag_r, rom_upper_enable_r;
  logic       watchdog_flag_one_r, sk, we, ls;
  logic [3:0] mem [64];
  int         fail_count = 0;
  int         checks = 0;
  int         cyc = 0;

  rrx_exec i_rrx_exec (.clk, .rst, .instr_valid, .instr, .ram_rdata, .ram_addr, .ram_wdata,
    .ram_we, .lookup_start, .lookup_done, .lookup_word, .watchdog_set, .skip_next, .acc_r,
    .upper_r, .file_ptr, .digit_ptr, .page_r, .wide_r, .carry_flag_r, .rom_upper_enable_r,
    .watchdog_flag_one_r);

  // ============================================================
  // RAM with same-cycle read, written on the strobe edge
  assign ram_rdata = mem[ram_addr];
  always @(posedge clk) begin
    if (ram_we === 1'h1) mem[ram_addr] <= ram_wdata;
  end
  always #4 clk = ~clk;

  // ============================================================
  // Drivers and comparison
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Leaves valid high so back-to-back words never double-drive a step
  task op(input logic [8:0] w);
    instr_valid <= 1'h1;
    instr <= w;
    #4;
    sk = skip_next;
    we = ram_we;
    ls = lookup_start;
    @(posedge clk);
  endtask
  task idle;
    instr_valid <= 1'h0;
    @(posedge clk);
  endtask
  task run(input logic [8:0] w);
    op(w);
    idle();
  endtask
  task lookup(input logic [8:0] w);
    lookup_done <= 1'h1;
    lookup_word <= w;
    @(posedge clk);
    lookup_done <= 1'h0;
    @(posedge clk);
  endtask
  task test_done;
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task t_regs;
    run(9'h0E9);
    chk("file_ptr", 9'h002, file_ptr);
    chk("digit_ptr", 9'h009, digit_ptr);
    run(`RRX_OPC_COPY_PTR_TO_ACC);
    chk("acc", 9'h009, acc_r);
    run(`RRX_OPC_COPY_ACC_TO_UPPER);
    chk("upper", 9'h009, upper_r);
    run(9'h0C6);
    run(`RRX_OPC_COPY_PTR_TO_ACC);
    run(`RRX_OPC_PACK_INTO_WIDE);
    chk("wide", 9'h096, wide_r);
    run(`RRX_OPC_COPY_UPPER_TO_ACC);
    chk("acc", 9'h009, acc_r);
    run(`RRX_OPC_LOAD_PAGE_PTR);
    chk("page", 9'h001, page_r);
    run(`RRX_OPC_COPY_ACC_TO_DPTR);
    chk("digit_ptr", 9'h009, digit_ptr);
    run(`RRX_OPC_UNPACK_WIDE);
    chk("acc", 9'h006, acc_r);
    chk("upper", 9'h009, upper_r);
    chk("carry", 9'h000, carry_flag_r);
  endtask
  // Chained pair loads, one of them after an idle gap
  task t_pair;
    op(9'h0C5);
    op(9'h0F7);
    idle();
    op(9'h0DA);
    op(`RRX_OPC_INC_DIGIT_PTR);
    idle();
    chk("file_ptr", 9'h000, file_ptr);
    chk("digit_ptr", 9'h006, digit_ptr);
  endtask
  task t_skip;
    run(9'h0CF);
    op(`RRX_OPC_INC_DIGIT_PTR);
    chk("skip", 9'h001, sk);
    op(`RRX_OPC_COPY_ACC_TO_UPPER);
    idle();
    chk("upper", 9'h009, upper_r);
    chk("digit_ptr", 9'h000, digit_ptr);
    op(`RRX_OPC_DEC_DIGIT_PTR);
    chk("skip", 9'h001, sk);
    op(`RRX_OPC_COPY_PTR_TO_ACC);
    idle();
    chk("acc", 9'h006, acc_r);
    chk("digit_ptr", 9'h00F, digit_ptr);
    run(`RRX_OPC_DEC_DIGIT_PTR);
    chk("skip", 9'h000, sk);
  endtask
  task t_ram;
    run(9'h0D0);
    op(9'h067);
    chk("ram_we", 9'h000, we);
    idle();
    chk("acc", 9'h005, acc_r);
    chk("file_ptr", 9'h002, file_ptr);
    chk("mem16", 9'h005, mem[16]);
    op(9'h06D);
    chk("ram_we", 9'h001, we);
    chk("skip", 9'h001, sk);
    op(`RRX_OPC_SWAP_ACC_RAM);
    chk("ram_we", 9'h000, we);
    idle();
    chk("acc", 9'h00A, acc_r);
    chk("mem32", 9'h005, mem[32]);
    chk("file_ptr", 9'h003, file_ptr);
    op(9'h068);
    chk("skip", 9'h001, sk);
    idle();
    chk("mem63", 9'h00A, mem[63]);
    run(`RRX_OPC_COPY_UPPER_TO_ACC);
    chk("acc", 9'h000, acc_r);
    op(9'h062);
    chk("ram_we", 9'h001, we);
    idle();
    chk("acc", 9'h00F, acc_r);
    chk("mem48", 9'h000, mem[48]);
    chk("file_ptr", 9'h001, file_ptr);
  endtask
  task t_flags;
    lookup(9'h1A5);
    chk("upper", 9'h00A, upper_r);
    chk("carry", 9'h000, carry_flag_r);
    op(9'h093);
    chk("lookup_start", 9'h001, ls);
    idle();
    run(`RRX_OPC_SET_ROM_UPPER);
    chk("upper_enable", 9'h001, rom_upper_enable_r);
    lookup(9'h1C3);
    chk("carry", 9'h001, carry_flag_r);
    watchdog_set <= 1'h1;
    @(posedge clk);
    watchdog_set <= 1'h0;
    @(posedge clk);
    chk("watchdog", 9'h001, watchdog_flag_one_r);
    op(`RRX_OPC_CLEAR_WATCHDOG);
    chk("skip", 9'h000, sk);
    idle();
    chk("watchdog", 9'h000, watchdog_flag_one_r);
    chk("carry", 9'h001, carry_flag_r);
    lookup(9'h034);
    chk("carry", 9'h000, carry_flag_r);
  endtask

  // ============================================================
  // Main sequence and hang guard
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 4'(i) ^ (4'(i >> 4) * 4'h5);
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_pair();
    t_skip();
    t_ram();
    t_flags();
    test_done();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      test_done();
    end
  end
endmodule
